// [src/pfm_pkg.sv]
package pfm_pkg;
	localparam int NUM_PADS = 24;
	localparam int NUM_ALTS = 9;
	localparam int NUM_FIXED = 4;
	localparam int NUM_IN_FUNCS = 4;
	localparam int NUM_CAND = 4;
	localparam int SEL_W = 4;
	localparam int CAND_W = 2;
	localparam int PAD_IDX_W = 5;

	localparam logic [SEL_W-1:0] ALT_ZERO = 4'h0;
	localparam logic [SEL_W-1:0] ALT_FIVE = 4'h5;
	localparam logic [SEL_W-1:0] ALT_LAST = 4'h8;
	localparam int LOW_BANK_FIRST = 1;
	localparam int LOW_BANK_LAST = 15;

	// Region in paddr[9:8], entry index in paddr[7:2]
	localparam logic [1:0] REGION_FUNC_SEL = 2'h0;
	localparam logic [1:0] REGION_PAD_CTL = 2'h1;
	localparam logic [1:0] REGION_IN_SEL = 2'h2;
	localparam logic [1:0] REGION_STATUS = 2'h3;
	localparam logic [11:0] ADDR_FUNC_SEL_BASE = 12'h000;
	localparam logic [11:0] ADDR_PAD_CTL_BASE = 12'h100;
	localparam logic [11:0] ADDR_IN_SEL_BASE = 12'h200;
	localparam logic [11:0] ADDR_PAD_LEVEL = 12'h300;
	localparam logic [11:0] ADDR_PAD_3V3 = 12'h304;

	typedef struct packed {
		logic input_enable;
		logic slow_slew;
		logic [2:0] drive;
		logic open_drain;
		logic pull_up;
		logic pull_enable;
		logic hysteresis;
	} pfm_elec_t;

	localparam int ELEC_W = $bits(pfm_elec_t);

	// Reset pull choice per pad; a pad in neither mask has no pull
	localparam logic [NUM_PADS-1:0] PULL_DOWN_RST = 24'h00_00F0;
	localparam logic [NUM_PADS-1:0] PULL_UP_RST = 24'h0F_0F00;
	// Pads that wake up as high-impedance outputs, input buffer off
	localparam logic [NUM_PADS-1:0] HIZ_OUT_RST = 24'hC0_0000;
	localparam logic [2:0] DRIVE_RST = 3'h0;

	typedef struct packed {
		logic o;
		logic oe;
	} pfm_drive_t;

	// Pads that may feed each multi-source input function
	localparam logic [PAD_IDX_W-1:0] IN_CAND [NUM_IN_FUNCS][NUM_CAND] = '{
		'{5'h02, 5'h08, 5'h10, 5'h14},
		'{5'h03, 5'h09, 5'h11, 5'h15},
		'{5'h04, 5'h0A, 5'h12, 5'h16},
		'{5'h05, 5'h0B, 5'h13, 5'h17}
	};
endpackage

// [src/pfm_pad_cell.sv]
`timescale 1ns/10ps
module pfm_pad_cell import pfm_pkg::*; (
	input wire logic [SEL_W-1:0] func_sel,
	input wire pfm_elec_t ctl,
	input wire logic is_3v3,
	input wire pfm_drive_t alt_drive [NUM_ALTS],
	input wire logic pad_in,
	output pfm_drive_t pad_drive,
	output pfm_elec_t elec,
	output logic [NUM_ALTS-1:0] alt_in
);
	pfm_drive_t chosen;

	always_comb begin
		chosen = '0;
		// Codes above the last alternative leave the pad undriven
		for (int a = 0; a < NUM_ALTS; a++) begin
			if (func_sel == SEL_W'(a)) begin
				chosen = alt_drive[a];
			end
		end
		pad_drive.o = chosen.o;
		pad_drive.oe = chosen.oe;
		if (ctl.open_drain) begin
			// Open drain only pulls low, released high
			pad_drive.o = 1'b0;
			pad_drive.oe = chosen.oe & ~chosen.o;
		end
		elec = ctl;
		// Pull resistors are dead at the high supply level
		elec.pull_enable = ctl.pull_enable & ~is_3v3;
		for (int a = 0; a < NUM_ALTS; a++) begin
			alt_in[a] = ctl.input_enable & pad_in & (func_sel == SEL_W'(a));
		end
	end
endmodule

// [src/pfm_pad_multiplexer.sv]
// Notes on behaviour
// - Each pad carries one of nine functions
// - Dedicated interface pads are fixed, unselectable
// - Input-select picks source pad per function
// - Reset function five; low bank pads zero
// - Per-pad electrical control register
// - Reset pads: inputs, some with pulls, some hi-Z
// - Pulls ineffective on 3.3V pads
`timescale 1ns/10ps
module pfm_pad_multiplexer import pfm_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire pfm_drive_t periph_drive [NUM_PADS][NUM_ALTS],
	output logic [NUM_ALTS-1:0] periph_in [NUM_PADS],
	output logic [NUM_IN_FUNCS-1:0] func_in,
	input wire logic [NUM_PADS-1:0] pad_in,
	input wire logic [NUM_PADS-1:0] pad_is_3v3,
	output logic [NUM_PADS-1:0] pad_o,
	output logic [NUM_PADS-1:0] pad_oe_n,
	output pfm_elec_t pad_elec [NUM_PADS],
	input wire pfm_drive_t fixed_periph_drive [NUM_FIXED],
	output logic [NUM_FIXED-1:0] fixed_periph_in,
	input wire logic [NUM_FIXED-1:0] fixed_pad_in,
	output logic [NUM_FIXED-1:0] fixed_pad_o,
	output logic [NUM_FIXED-1:0] fixed_pad_oe_n
);
	logic [SEL_W-1:0] func_sel [NUM_PADS];
	logic [SEL_W-1:0] next_func_sel [NUM_PADS];
	pfm_elec_t pad_ctl [NUM_PADS];
	pfm_elec_t next_pad_ctl [NUM_PADS];
	logic [CAND_W-1:0] in_sel [NUM_IN_FUNCS];
	logic [CAND_W-1:0] next_in_sel [NUM_IN_FUNCS];

	logic [NUM_PADS-1:0] next_pad_o;
	logic [NUM_PADS-1:0] next_pad_oe_n;
	pfm_elec_t next_pad_elec [NUM_PADS];
	logic [NUM_ALTS-1:0] next_periph_in [NUM_PADS];
	logic [NUM_IN_FUNCS-1:0] next_func_in;
	logic [NUM_FIXED-1:0] next_fixed_pad_o;
	logic [NUM_FIXED-1:0] next_fixed_pad_oe_n;
	logic [NUM_FIXED-1:0] next_fixed_periph_in;

	pfm_drive_t cell_drive [NUM_PADS];
	pfm_elec_t cell_elec [NUM_PADS];
	logic [NUM_ALTS-1:0] cell_alt_in [NUM_PADS];

	logic [1:0] region;
	logic [5:0] index;
	logic access;
	logic bad_addr;
	logic do_write;

	// Bus decode
	assign region = paddr[9:8];
	assign index = paddr[7:2];
	assign access = psel & penable;
	assign pready = 1'b1;

	always_comb begin
		bad_addr = 1'b0;
		prdata = '0;
		if (paddr[1:0] != 2'h0 || paddr[11:10] != 2'h0) begin
			bad_addr = 1'b1;
		end else begin
			unique case (region)
				REGION_FUNC_SEL: begin
					if (index < 6'(NUM_PADS)) begin
						prdata = 32'(func_sel[index[PAD_IDX_W-1:0]]);
					end else begin
						bad_addr = 1'b1;
					end
				end
				REGION_PAD_CTL: begin
					if (index < 6'(NUM_PADS)) begin
						prdata = 32'(pad_ctl[index[PAD_IDX_W-1:0]]);
					end else begin
						bad_addr = 1'b1;
					end
				end
				REGION_IN_SEL: begin
					if (index < 6'(NUM_IN_FUNCS)) begin
						prdata = 32'(in_sel[index[CAND_W-1:0]]);
					end else begin
						bad_addr = 1'b1;
					end
				end
				REGION_STATUS: begin
					if ({2'h0, paddr[9:0]} == ADDR_PAD_LEVEL) begin
						prdata = 32'(pad_in);
					end else if ({2'h0, paddr[9:0]} == ADDR_PAD_3V3) begin
						prdata = 32'(pad_is_3v3);
					end else begin
						bad_addr = 1'b1;
					end
				end
			endcase
		end
		pslverr = access & bad_addr;
	end

	// Status registers are read-only, so writes to them are silently dropped
	assign do_write = access & pwrite & ~bad_addr;

	// Register file
	always_comb begin
		next_func_sel = func_sel;
		next_pad_ctl = pad_ctl;
		next_in_sel = in_sel;
		if (do_write) begin
			for (int p = 0; p < NUM_PADS; p++) begin
				if (index == 6'(p) && region == REGION_FUNC_SEL) begin
					next_func_sel[p] = pwdata[SEL_W-1:0];
				end
				if (index == 6'(p) && region == REGION_PAD_CTL) begin
					next_pad_ctl[p] = pwdata[ELEC_W-1:0];
				end
			end
			for (int f = 0; f < NUM_IN_FUNCS; f++) begin
				if (index == 6'(f) && region == REGION_IN_SEL) begin
					next_in_sel[f] = pwdata[CAND_W-1:0];
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			for (int p = 0; p < NUM_PADS; p++) begin
				if (p >= LOW_BANK_FIRST && p <= LOW_BANK_LAST) begin
					func_sel[p] <= ALT_ZERO;
				end else begin
					func_sel[p] <= ALT_FIVE;
				end
				pad_ctl[p].input_enable <= ~HIZ_OUT_RST[p];
				pad_ctl[p].slow_slew <= 1'b1;
				pad_ctl[p].drive <= DRIVE_RST;
				pad_ctl[p].open_drain <= 1'b0;
				pad_ctl[p].pull_up <= PULL_UP_RST[p];
				pad_ctl[p].pull_enable <= PULL_UP_RST[p] | PULL_DOWN_RST[p];
				pad_ctl[p].hysteresis <= 1'b0;
			end
			for (int f = 0; f < NUM_IN_FUNCS; f++) begin
				in_sel[f] <= '0;
			end
		end else begin
			func_sel <= next_func_sel;
			pad_ctl <= next_pad_ctl;
			in_sel <= next_in_sel;
		end
	end

	// Pad cells
	generate
		for (genvar p = 0; p < NUM_PADS; p++) begin : g_pad
			pfm_pad_cell u_cell (
				.func_sel(func_sel[p]),
				.ctl(pad_ctl[p]),
				.is_3v3(pad_is_3v3[p]),
				.alt_drive(periph_drive[p]),
				.pad_in(pad_in[p]),
				.pad_drive(cell_drive[p]),
				.elec(cell_elec[p]),
				.alt_in(cell_alt_in[p])
			);
		end
	endgenerate

	// Registered pad side so a mux change cannot glitch neighbours
	always_comb begin
		for (int p = 0; p < NUM_PADS; p++) begin
			next_pad_o[p] = cell_drive[p].o;
			next_pad_oe_n[p] = ~cell_drive[p].oe;
			next_pad_elec[p] = cell_elec[p];
			next_periph_in[p] = cell_alt_in[p];
		end
		for (int f = 0; f < NUM_IN_FUNCS; f++) begin
			// Source pad must also sit on an input-capable setting
			next_func_in[f] = pad_in[IN_CAND[f][in_sel[f]]]
				& pad_ctl[IN_CAND[f][in_sel[f]]].input_enable;
		end
		for (int d = 0; d < NUM_FIXED; d++) begin
			next_fixed_pad_o[d] = fixed_periph_drive[d].o;
			next_fixed_pad_oe_n[d] = ~fixed_periph_drive[d].oe;
			next_fixed_periph_in[d] = fixed_pad_in[d];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pad_o <= '0;
			pad_oe_n <= '1;
			for (int p = 0; p < NUM_PADS; p++) begin
				pad_elec[p] <= '0;
				periph_in[p] <= '0;
			end
			func_in <= '0;
			fixed_pad_o <= '0;
			fixed_pad_oe_n <= '1;
			fixed_periph_in <= '0;
		end else begin
			pad_o <= next_pad_o;
			pad_oe_n <= next_pad_oe_n;
			pad_elec <= next_pad_elec;
			periph_in <= next_periph_in;
			func_in <= next_func_in;
			fixed_pad_o <= next_fixed_pad_o;
			fixed_pad_oe_n <= next_fixed_pad_oe_n;
			fixed_periph_in <= next_fixed_periph_in;
		end
	end
endmodule

// [sim/pfm_pad_multiplexer_chk.sv]
`timescale 1ns/10ps
module pfm_pad_multiplexer_chk import pfm_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [NUM_PADS-1:0] pad_oe_n,
	input wire pfm_drive_t fixed_periph_drive [NUM_FIXED],
	input wire logic [NUM_FIXED-1:0] fixed_periph_in,
	input wire logic [NUM_FIXED-1:0] fixed_pad_in,
	input wire logic [NUM_FIXED-1:0] fixed_pad_o,
	input wire logic [NUM_FIXED-1:0] fixed_pad_oe_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence acc;
		psel && penable;
	endsequence
	sequence bad_sel_wr;
		acc ##0 (pwrite && paddr == ADDR_FUNC_SEL_BASE && pwdata[3:0] > ALT_LAST);
	endsequence
	a_zero_wait: assert property (acc |-> pready) else $error("Access not ready");
	a_misalign_err: assert property (acc ##0 paddr[1:0] != 2'h0 |-> pslverr)
		else $error("Misaligned access accepted");
	a_func_sel_ok: assert property (acc ##0 (paddr[11:8] == 4'h0 && paddr[7:2] < 6'h18
		&& paddr[1:0] == 2'h0) |-> !pslverr) else $error("Mapped select refused");
	a_err_data_zero: assert property (pslverr |-> prdata == 32'h0)
		else $error("Error read carries data");
	a_bad_sel_hiz: assert property (bad_sel_wr |=> ##1 pad_oe_n[0])
		else $error("Unused select drives pad");
	a_fixed_out: assert property (1'b1 |=> fixed_pad_o[0] == $past(fixed_periph_drive[0].o)
		&& fixed_pad_oe_n[0] == !$past(fixed_periph_drive[0].oe))
		else $error("Fixed lane output wrong");
	a_fixed_in: assert property (1'b1 |=> fixed_periph_in == $past(fixed_pad_in))
		else $error("Fixed lane input wrong");
	a_reset_undriven: assert property (disable iff (1'b0) rst |=> pad_oe_n == '1
		&& fixed_pad_oe_n == '1) else $error("Pad driven in reset");
endmodule
bind pfm_pad_multiplexer pfm_pad_multiplexer_chk u_chk (.clk(clk), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .pad_oe_n(pad_oe_n),
	.fixed_periph_drive(fixed_periph_drive), .fixed_periph_in(fixed_periph_in),
	.fixed_pad_in(fixed_pad_in), .fixed_pad_o(fixed_pad_o), .fixed_pad_oe_n(fixed_pad_oe_n));

// [sim/tb.sv]
`timescale 1ns/10ps
module tb import pfm_pkg::*;;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	pfm_drive_t periph_drive [NUM_PADS][NUM_ALTS];
	pfm_drive_t fixed_periph_drive [NUM_FIXED];
	logic [NUM_ALTS-1:0] periph_in [NUM_PADS];
	pfm_elec_t pad_elec [NUM_PADS];
	logic [NUM_IN_FUNCS-1:0] func_in;
	logic [NUM_PADS-1:0] pad_in, pad_is_3v3, pad_o, pad_oe_n;
	logic [NUM_FIXED-1:0] fixed_periph_in, fixed_pad_in, fixed_pad_o, fixed_pad_oe_n;
	int errors, samples_checked;
	pfm_pad_multiplexer u_pfm_pad_multiplexer (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .periph_drive(periph_drive),
		.periph_in(periph_in), .func_in(func_in), .pad_in(pad_in), .pad_is_3v3(pad_is_3v3),
		.pad_o(pad_o), .pad_oe_n(pad_oe_n), .pad_elec(pad_elec),
		.fixed_periph_drive(fixed_periph_drive), .fixed_periph_in(fixed_periph_in),
		.fixed_pad_in(fixed_pad_in), .fixed_pad_o(fixed_pad_o), .fixed_pad_oe_n(fixed_pad_oe_n));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			errors++;
			summarize();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Write lands at one edge, pads follow at the next
	task automatic settle();
		repeat (2) @(posedge clk);
	endtask
	task automatic t_reset();
		for (int p = 0; p < NUM_PADS; p++) begin
			apb(1'b0, ADDR_FUNC_SEL_BASE + 12'(4 * p), 32'h0);
			chk(rd, (p >= LOW_BANK_FIRST && p <= LOW_BANK_LAST) ? ALT_ZERO : ALT_FIVE);
			apb(1'b0, ADDR_PAD_CTL_BASE + 12'(4 * p), 32'h0);
			chk(rd, {~HIZ_OUT_RST[p], 1'b1, DRIVE_RST, 1'b0, PULL_UP_RST[p],
				PULL_UP_RST[p] | PULL_DOWN_RST[p], 1'b0});
		end
		chk(pad_oe_n, 32'h00FF_FFFF);
		$display("test reset done");
	endtask
	task automatic t_route();
		pad_in <= 24'h1;
		for (int a = 0; a <= NUM_ALTS; a++) begin
			for (int k = 0; k < NUM_ALTS; k++) periph_drive[0][k] <= {k == a, 1'b1};
			apb(1'b1, ADDR_FUNC_SEL_BASE, 32'(a));
			settle();
			chk(pad_o[0], a < NUM_ALTS);
			chk(pad_oe_n[0], a >= NUM_ALTS);
			chk(periph_in[0], (a < NUM_ALTS) ? 32'h1 << a : 32'h0);
		end
		for (int c = 0; c < NUM_CAND; c++) begin
			pad_in <= 24'h1 << IN_CAND[0][c];
			apb(1'b1, ADDR_IN_SEL_BASE, 32'(c));
			settle();
			chk(func_in, 32'h1);
			pad_in <= 24'hFF_FFFF ^ (24'h1 << IN_CAND[0][c]);
			settle();
			chk(func_in[0], 32'h0);
		end
		$display("test route done");
	endtask
	task automatic t_pad();
		// Slow slew with a modest drive, open drain
		apb(1'b1, ADDR_PAD_CTL_BASE + 12'h020, 32'h1AB);
		pad_is_3v3 <= 24'h100;
		periph_drive[8][0] <= 2'h3;
		settle();
		chk(pad_elec[8], 32'h1A9);
		chk(pad_o[8], 32'h0);
		chk(pad_oe_n[8], 32'h1);
		apb(1'b1, ADDR_PAD_CTL_BASE + 12'h022, 32'h0);
		chk(err, 32'h1);
		apb(1'b0, ADDR_PAD_CTL_BASE + 12'h020, 32'h0);
		chk(rd, 32'h1AB);
		pad_is_3v3 <= 24'h0;
		periph_drive[8][0] <= 2'h1;
		settle();
		chk(pad_elec[8], 32'h1AB);
		chk(pad_oe_n[8], 32'h0);
		apb(1'b0, 12'h060, 32'h0);
		chk(err, 32'h1);
		fixed_periph_drive[1] <= 2'h3;
		fixed_pad_in <= 4'hA;
		settle();
		chk(fixed_pad_o, 32'h2);
		chk(fixed_pad_oe_n, 32'hD);
		chk(fixed_periph_in, 32'hA);
		$display("test pad done");
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		{rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
		{pad_in, pad_is_3v3, fixed_pad_in} = '0;
		for (int p = 0; p < NUM_PADS; p++) periph_drive[p] = '{default: '0};
		fixed_periph_drive = '{default: '0};
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_route();
		t_pad();
		summarize();
	end
endmodule
